// ===== hdl/mmne_exec.sv
`timescale 1ns/10ps
// Overview of operation
// - 0000 1110 loads literal into work
// - literal load: one word, write q4
// - 0110 111a copies work to file
// - 8-bit address spans 256-byte bank
// - access bit picks access or selected bank
// - extended mode indexes offsets up to 95
// - 0000 1101 multiplies work by literal
// - 16-bit product to high/low registers
// - multiplies leave all status flags alone
// - 0000 001a multiplies work by file
// - 0110 110a negates file, two's complement
module mmne_exec (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [15:0] i_instr,
  input wire logic [7:0] i_bank_sel,
  input wire logic i_ext_en,
  input wire logic [11:0] i_index_base,
  input wire logic [7:0] i_file_rdata,
  output logic [1:0] o_qphase,
  output logic [11:0] o_file_addr,
  output logic o_file_rd,
  output logic o_file_we,
  output logic [7:0] o_file_wdata,
  output logic [7:0] o_work,
  output logic [7:0] o_product_high,
  output logic [7:0] o_product_low,
  output logic o_known
);
  // state registers, one next-value twin per flop
  // quarter-cycle counter, wraps q4 back to q1
  logic [1:0] qph_r, qph_nxt;
  mmne_pkg::mmne_op_t op_r, op_nxt; // op decoded in q1
  logic [7:0] lit_r, lit_nxt; // literal or file offset
  logic [11:0] addr_r, addr_nxt; // resolved data address
  logic [7:0] opnd_r, opnd_nxt; // operand read in q2
  logic [15:0] res_r, res_nxt; // result formed in q3
  logic [7:0] work_r, work_nxt; // work register
  logic [7:0] product_high_r, product_high_nxt; // product high byte
  logic [7:0] product_low_r, product_low_nxt; // product low byte
  logic rd_r, rd_nxt; // file read strobe, q2 only
  logic we_r, we_nxt; // file write strobe, one cycle
  // write data holds between writes; only meaningful with the strobe
  logic [7:0] wdata_r, wdata_nxt;
  logic known_r, known_nxt; // decoded word is one of ours
  // decode helpers, purely combinational on the held word
  mmne_pkg::mmne_op_t dec_op; // op class of the held word
  logic [11:0] dec_addr; // 12-bit data address
  logic dec_file; // op addresses the file space

  // opcode decode and bank resolution, combinational on the held word
  // the word only matters at the q1 edge, so settling elsewhere is harmless
  always_comb begin
    // defaults: an unknown word decodes to no operation
    dec_op = mmne_pkg::MMNE_NONE;
    dec_file = 1'b0;
    if (i_instr[15:8] == mmne_pkg::OP_LOAD_LIT) begin
      dec_op = mmne_pkg::MMNE_LOAD_LIT;
    end else if (i_instr[15:8] == mmne_pkg::OP_MUL_LIT) begin
      dec_op = mmne_pkg::MMNE_MUL_LIT;
    end else if (i_instr[15:9] == mmne_pkg::OP_MUL_FILE) begin
      dec_op = mmne_pkg::MMNE_MUL_FILE;
      dec_file = 1'b1;
    end else if (i_instr[15:9] == mmne_pkg::OP_MOVE_FILE) begin
      dec_op = mmne_pkg::MMNE_MOVE_FILE;
      dec_file = 1'b1;
    end else if (i_instr[15:9] == mmne_pkg::OP_NEG_FILE) begin
      dec_op = mmne_pkg::MMNE_NEG_FILE;
      dec_file = 1'b1;
    end
    // address is formed for every word; literal ops simply ignore it
    // access bit selects bank source
    if (i_instr[8]) begin
      // full 256-byte offset in selected bank
      // only the low nibble of the bank select is a bank number
      dec_addr = {i_bank_sel[3:0], i_instr[7:0]};
    end else if (i_ext_en && i_instr[7:0] <= mmne_pkg::IDX_LIMIT) begin
      // wraps at the 4k edge; software keeps the base sane
      dec_addr = i_index_base + {4'h0, i_instr[7:0]};
    // access bank, lower part from bank 0
    end else if (i_instr[7:0] < mmne_pkg::ACC_SPLIT) begin
      dec_addr = {4'h0, i_instr[7:0]};
    // access bank, upper part from the top bank
    end else begin
      dec_addr = {mmne_pkg::ACC_HIGH_BANK, i_instr[7:0]};
    end
  end

  // next-state logic for the four quarter-cycles
  // every op walks all four quarters, so one cycle per word is fixed
  always_comb begin
    // one instruction cycle of four quarters
    qph_nxt = (qph_r == mmne_pkg::QPH_LAST) ? 2'h0 : qph_r + 2'h1;
    // hold by default; strobes fall back to idle
    op_nxt = op_r;
    lit_nxt = lit_r;
    addr_nxt = addr_r;
    opnd_nxt = opnd_r;
    res_nxt = res_r;
    work_nxt = work_r;
    product_high_nxt = product_high_r;
    product_low_nxt = product_low_r;
    rd_nxt = 1'b0;
    we_nxt = 1'b0;
    wdata_nxt = wdata_r;
    known_nxt = known_r;
    unique case (qph_r)
      // q1 decode: latch op, literal and address
      2'h0: begin
        op_nxt = dec_op;
        lit_nxt = i_instr[7:0];
        addr_nxt = dec_addr;
        // move only writes the file, so it skips the read
        rd_nxt = dec_file && (dec_op != mmne_pkg::MMNE_MOVE_FILE);
        known_nxt = (dec_op != mmne_pkg::MMNE_NONE);
      end
      // q2 read: literal or file data becomes the operand
      2'h1: begin
        // file operand sampled one edge after the read strobe rises
        if (op_r == mmne_pkg::MMNE_MUL_FILE || op_r == mmne_pkg::MMNE_NEG_FILE) begin
          opnd_nxt = i_file_rdata;
        // literal ops reuse the latched literal
        end else begin
          opnd_nxt = lit_r;
        end
      end
      // q3 process
      2'h2: begin
        unique case (op_r)
          // unsigned product, no flags formed
          // zero-extended so the full 16-bit product survives
          mmne_pkg::MMNE_MUL_LIT, mmne_pkg::MMNE_MUL_FILE: begin
            res_nxt = {8'h00, work_r} * {8'h00, opnd_r};
          end
          mmne_pkg::MMNE_NEG_FILE: res_nxt = {8'h00, (~opnd_r) + 8'h01};
          // move passes the work register through
          mmne_pkg::MMNE_MOVE_FILE: res_nxt = {8'h00, work_r};
          // literal load, and unused codes, pass the operand
          default: res_nxt = {8'h00, opnd_r};
        endcase
      end
      // q4 write the destination
      2'h3: begin
        unique case (op_r)
          mmne_pkg::MMNE_LOAD_LIT: work_nxt = res_r[7:0];
          mmne_pkg::MMNE_MUL_LIT, mmne_pkg::MMNE_MUL_FILE: begin
            product_high_nxt = res_r[15:8];
            product_low_nxt = res_r[7:0];
          end
          // work copied to the file
          // negate shares the write path with its own result
          mmne_pkg::MMNE_MOVE_FILE, mmne_pkg::MMNE_NEG_FILE: begin
            we_nxt = 1'b1;
            wdata_nxt = res_r[7:0];
          end
          // unknown words write nothing
          default: begin
            we_nxt = 1'b0;
          end
        endcase
      end
    endcase
  end

  // state registers, frozen while the clock enable is low
  // reset wins over the enable, so a stalled core still comes out of reset
  always_ff @(posedge i_clk_sys) begin
    // synchronous reset back to q1 with nothing pending
    if (i_rst) begin
      qph_r <= mmne_pkg::QPH_RST;
      op_r <= mmne_pkg::MMNE_NONE;
      lit_r <= 8'h00;
      addr_r <= 12'h000;
      opnd_r <= 8'h00;
      res_r <= 16'h0000;
      work_r <= mmne_pkg::WORK_RST;
      product_high_r <= mmne_pkg::PROD_RST;
      product_low_r <= mmne_pkg::PROD_RST;
      rd_r <= 1'b0;
      we_r <= 1'b0;
      wdata_r <= 8'h00;
      known_r <= 1'b0;
    end else if (i_ce) begin
      qph_r <= qph_nxt;
      op_r <= op_nxt;
      lit_r <= lit_nxt;
      addr_r <= addr_nxt;
      opnd_r <= opnd_nxt;
      res_r <= res_nxt;
      work_r <= work_nxt;
      product_high_r <= product_high_nxt;
      product_low_r <= product_low_nxt;
      rd_r <= rd_nxt;
      we_r <= we_nxt;
      wdata_r <= wdata_nxt;
      known_r <= known_nxt;
    end
  end

  // outputs straight from flops
  // no logic after the flops, so the neighbours see clean edges
  assign o_qphase = qph_r;
  assign o_file_addr = addr_r;
  assign o_file_rd = rd_r;
  assign o_file_we = we_r;
  assign o_file_wdata = wdata_r;
  assign o_work = work_r;
  assign o_product_high = product_high_r;
  assign o_product_low = product_low_r;
  assign o_known = known_r;
endmodule

// ===== hdl/mmne_pkg.sv
package mmne_pkg;
  // opcode patterns, upper bits of the 16-bit word
  localparam logic [7:0] OP_LOAD_LIT = 8'h0e; // 0000 1110
  localparam logic [7:0] OP_MUL_LIT = 8'h0d; // 0000 1101
  localparam logic [6:0] OP_MUL_FILE = 7'h01; // 0000 001a
  localparam logic [6:0] OP_MOVE_FILE = 7'h37; // 0110 111a
  localparam logic [6:0] OP_NEG_FILE = 7'h36; // 0110 110a
  // highest offset handled by indexed literal offset mode
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  // access bank: offsets below 0x60 from bank 0, the rest from bank 0xf
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
  // reset values
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [7:0] PROD_RST = 8'h00;
  localparam logic [1:0] QPH_RST = 2'h0;
  // index of the last quarter-cycle in an instruction cycle
  localparam logic [1:0] QPH_LAST = 2'h3;
  typedef enum logic [2:0] {
    MMNE_NONE, MMNE_LOAD_LIT, MMNE_MOVE_FILE, MMNE_MUL_LIT, MMNE_MUL_FILE, MMNE_NEG_FILE
  } mmne_op_t;
endpackage

// ===== tb/mmne_exec_asserts.sv
`timescale 1ns/10ps
// passive view of the executor ports
module mmne_exec_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [15:0] i_instr,
  input wire logic [7:0] i_bank_sel,
  input wire logic [7:0] i_file_rdata,
  input wire logic [1:0] o_qphase,
  input wire logic [11:0] o_file_addr,
  input wire logic o_file_we,
  input wire logic [7:0] o_file_wdata,
  input wire logic [7:0] o_work,
  input wire logic [7:0] o_product_high,
  input wire logic [7:0] o_product_low
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // decode edge, opcode and operand bytes
  wire q1 = i_ce && o_qphase == 2'h0;
  wire [7:0] op = i_instr[15:8];
  wire [7:0] f = i_instr[7:0];
  wire [15:0] pr = {o_product_high, o_product_low};
  wire fop = op[7:1] inside {mmne_pkg::OP_MUL_FILE, mmne_pkg::OP_NEG_FILE,
    mmne_pkg::OP_MOVE_FILE};
  // a stall breaks the fixed spacing, so only unbroken runs are judged
  sequence s3; i_ce [*3]; endsequence
  property p_qph; !i_rst |=> o_qphase == $past(o_qphase) + {1'b0, $past(i_ce)}; endproperty
  a_qph: assert property (p_qph) else $error("quarter step");
  property p_load; q1 && op == mmne_pkg::OP_LOAD_LIT ##1 s3 |=> o_work == $past(f, 4);
  endproperty
  a_load: assert property (p_load) else $error("literal load");
  property p_mull; q1 && op == mmne_pkg::OP_MUL_LIT ##1 s3 |=>
    pr == $past(o_work, 4) * $past(f, 4) && $stable(o_work); endproperty
  a_mull: assert property (p_mull) else $error("literal product");
  property p_mulf; q1 && op[7:1] == mmne_pkg::OP_MUL_FILE ##1 s3 |=>
    pr == $past(o_work, 4) * $past(i_file_rdata, 3); endproperty
  a_mulf: assert property (p_mulf) else $error("file product");
  property p_move; q1 && op[7:1] == mmne_pkg::OP_MOVE_FILE ##1 s3 |=>
    o_file_we && o_file_wdata == $past(o_work, 4); endproperty
  a_move: assert property (p_move) else $error("move write");
  property p_neg; q1 && op[7:1] == mmne_pkg::OP_NEG_FILE ##1 s3 |=>
    o_file_we && o_file_wdata == 8'h00 - $past(i_file_rdata, 3); endproperty
  a_neg: assert property (p_neg) else $error("negate write");
  property p_bank; q1 && fop && i_instr[8] |=>
    o_file_addr == {$past(i_bank_sel[3:0]), $past(f)}; endproperty
  a_bank: assert property (p_bank) else $error("bank address");
  property p_pulse; o_file_we && i_ce |=> !o_file_we; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse");
endmodule
bind mmne_exec mmne_exec_chk mmne_exec_chk_i (.*);

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_ext_en = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [7:0] i_bank_sel = 8'h03, i_file_rdata = 8'h00;
  logic [11:0] i_index_base = 12'h200;
  logic [1:0] o_qphase;
  logic [11:0] o_file_addr;
  logic o_file_rd, o_file_we, o_known;
  logic [7:0] o_file_wdata, o_work, o_product_high, o_product_low;
  int err_count = 0, n_checks = 0;
  // packed views for compact compares
  wire [15:0] pr = {o_product_high, o_product_low};
  wire [15:0] ad = {4'h0, o_file_addr};
  wire [15:0] wr = {7'h00, o_file_we, o_file_wdata};
  mmne_exec mmne_exec_i (.*);
  initial forever #5 i_clk_sys = ~i_clk_sys;
  task automatic c(input string n, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one instruction per four edges, called at a falling edge
  task automatic x(input logic [15:0] ins, input logic [7:0] rd);
    i_instr = ins;
    i_file_rdata = rd;
    repeat (4) @(negedge i_clk_sys);
  endtask
  // literal load and literal multiply
  task automatic t_lit;
    x(16'h0ee2, 8'h00);
    c("known", 16'h0001, {15'h0000, o_known});
    c("phase", 16'h0000, {14'h0000, o_qphase});
    x(16'h0dc4, 8'h00);
    c("prod", 16'had08, pr);
    c("work", 16'h00e2, {8'h00, o_work});
  endtask
  // clock enable low freezes the quarter count mid-instruction
  task automatic t_stall;
    i_instr = 16'h0e5a;
    @(negedge i_clk_sys);
    i_ce = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    c("phase", 16'h0001, {14'h0000, o_qphase});
    c("work", 16'h00e2, {8'h00, o_work});
    i_ce = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    c("work", 16'h005a, {8'h00, o_work});
  endtask
  // banked multiply with its read strobe, then access bank move
  task automatic t_file;
    x(16'h0ec4, 8'h00);
    i_instr = 16'h03ff;
    i_file_rdata = 8'hb5;
    @(negedge i_clk_sys);
    c("rd", 16'h0001, {15'h0000, o_file_rd});
    repeat (3) @(negedge i_clk_sys);
    c("prod", 16'h8a94, pr);
    c("work", 16'h00c4, {8'h00, o_work});
    c("addr", 16'h03ff, ad);
    x(16'h6e80, 8'h00);
    c("addr", 16'h0f80, ad);
    c("write", 16'h01c4, wr);
  endtask
  // indexed negate at the top offset, then just past it
  task automatic t_neg;
    i_ext_en = 1'b1;
    x(16'h6c5f, 8'h3a);
    c("addr", 16'h025f, ad);
    c("write", 16'h01c6, wr);
    x(16'h6c60, 8'h01);
    c("addr", 16'h0f60, ad);
    c("write", 16'h01ff, wr);
    i_ext_en = 1'b0;
  endtask
  // undecoded word changes nothing, then a reset in mid-run
  task automatic t_bad;
    x(16'h0000, 8'h00);
    c("known", 16'h0000, {15'h0000, o_known});
    c("we", 16'h0000, {15'h0000, o_file_we});
    c("prod", 16'h8a94, pr);
    c("work", 16'h00c4, {8'h00, o_work});
    i_rst = 1'b1;
    @(negedge i_clk_sys);
    i_rst = 1'b0;
    c("work", {8'h00, mmne_pkg::WORK_RST}, {8'h00, o_work});
    c("prod", {mmne_pkg::PROD_RST, mmne_pkg::PROD_RST}, pr);
    c("phase", {14'h0000, mmne_pkg::QPH_RST}, {14'h0000, o_qphase});
    x(16'h0e11, 8'h00);
    c("work", 16'h0011, {8'h00, o_work});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'b0;
    t_lit;
    t_stall;
    t_file;
    t_neg;
    t_bad;
    tally_and_finish;
  end
  // ten instructions, a stall and a reset need about 500 ns
  initial begin
    #2000;
    err_count++;
    tally_and_finish;
  end
endmodule
